// ---- rtl/pcg_consts.vh ----
// Constants for the port C general purpose block
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH
`define PCG_PIN_LEVELS_IDX 8'h13
`define PCG_DIRECTION_IDX 8'h14
`define PCG_OUTPUT_LATCH_IDX 8'h15
`define PCG_ALT_CTRL_IDX 8'h16
`define PCG_ADDR_LSB 2
`define PCG_ADDR_MSB 9
`define PCG_BYTE_RESET 8'h00
`define PCG_ALT_GPUD_BIT 0
`define PCG_ALT_ASYNC_BIT 1
`define PCG_ALT_TWI_BIT 2
`define PCG_ALT_RESET 3'h0
`define PCG_OSC_OUT_PIN 7
`define PCG_OSC_IN_PIN 6
`define PCG_TW_DATA_PIN 1
`define PCG_TW_CLOCK_PIN 0
`define PCG_SPIKE_NS 50
`define PCG_CLK_PERIOD_NS 10
`define PCG_HTRANS_NONSEQ 2'h2
`define PCG_HTRANS_SEQ 2'h3
`endif

// ---- rtl/pcg_sync2.v ----
// Two flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module pcg_sync2 #(
	parameter WIDTH = 8
) (
	input wire hclk,
	input wire hresetn,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
reg [WIDTH-1:0] meta_ff;
reg [WIDTH-1:0] sync_ff;
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		meta_ff <= {WIDTH{1'b0}};
		sync_ff <= {WIDTH{1'b0}};
	end else begin
		meta_ff <= async_in;
		sync_ff <= meta_ff;
	end
end
assign sync_out = sync_ff;
endmodule

// ---- rtl/pcg_spike_filter.v ----
// Spike filter: level must stay stable for a minimum count
`timescale 1ns/1ps
module pcg_spike_filter #(
	parameter CNT_W = 4,
	parameter [CNT_W-1:0] STABLE_CYCLES = 4'h5
) (
	input wire hclk,
	input wire hresetn,
	input wire level_in,
	output wire level_out
);
reg out_ff;
reg [CNT_W-1:0] cnt_ff;
reg [CNT_W-1:0] nxt_cnt;
reg nxt_out;
always @* begin
	nxt_out = out_ff;
	nxt_cnt = {CNT_W{1'b0}};
	if (level_in != out_ff) begin
		if (cnt_ff >= STABLE_CYCLES - 1'b1)
			nxt_out = level_in;
		else
			nxt_cnt = cnt_ff + 1'b1;
	end
end
// Idle bus level is high, so filter starts high
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		out_ff <= 1'b1;
		cnt_ff <= {CNT_W{1'b0}};
	end else begin
		out_ff <= nxt_out;
		cnt_ff <= nxt_cnt;
	end
end
assign level_out = out_ff;
endmodule

// ---- rtl/pcg_port_c.v ----
// Port C general purpose I/O with alternate functions, AHB-Lite slave
//
// Overview of operation
// RULE1 - Each direction bit set makes its pin an output, cleared an input.
// RULE2 - An output pin is driven push-pull with its latch bit value.
// RULE3 - An input pin with latch one gets a pull-up unless pull-ups off.
// RULE4 - Pull-up is off for latch zero, output pins or global disable.
// RULE5 - Latch reads return stored bits, pin-level reads return pins.
// RULE6 - Pin levels at index 13h have no storage and show live levels.
// RULE7 - Reset tri-states every pin at once, with no clock needed.
// RULE8 - All eight pins behave the same as plain digital I/O; pins 7, 6, 1 and 0 go to alternates when selected.
// RULE9 - With the async timer select set, pin 7 is the oscillator output.
// RULE10 - With the async timer select set, pin 6 is the oscillator input.
// RULE11 - With two-wire enabled, pin 1 is open-drain data, spike filtered.
// RULE12 - With two-wire enabled, pin 0 is the clock line, spike filtered.
// RULE13 - Pin levels are synchronised before any read or consumer except the oscillator input on pin 6.
// RULE14 - Output latch sits at index 15h, read/write, reset to zero.
// RULE15 - Direction register sits at index 14h, read/write, reset zero.
// RULE16 - The pin synchroniser has two flops on the system clock.
`timescale 1ns/1ps
`include "pcg_consts.vh"
module pcg_port_c #(
	parameter WIDTH = 8
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [WIDTH-1:0] port_pin_in,
	output wire [WIDTH-1:0] port_pin_out,
	output wire [WIDTH-1:0] port_pin_oe,
	output wire [WIDTH-1:0] port_pin_pullup,
	output wire [WIDTH-1:0] port_pin_slew_limit,
	output wire [WIDTH-1:0] c_pin_sync,
	input wire osc_amp_out,
	output wire osc_amp_in,
	input wire tw_data_drive_low,
	input wire tw_clock_drive_low,
	output wire tw_data_in,
	output wire tw_clock_in,
	output wire async_timer_clock_select,
	output wire two_wire_enable
);

////////////////////////////////////////////////////////////////////////////
localparam integer SPIKE_CYC =
	(`PCG_SPIKE_NS + `PCG_CLK_PERIOD_NS - 1) / `PCG_CLK_PERIOD_NS;

reg [WIDTH-1:0] c_output_latch_ff;
reg [WIDTH-1:0] c_direction_reg_ff;
reg [2:0] alt_ctrl_ff;
reg wr_pend_ff;
reg rd_pend_ff;
reg [7:0] idx_ff;
reg [31:0] rdata_ff;
reg [31:0] nxt_rdata;
wire [7:0] idx_a;
wire xfer;
wire [WIDTH-1:0] c_pin_levels;
wire global_pullup_disable;
wire tw_data_filt;
wire tw_clock_filt;

assign global_pullup_disable = alt_ctrl_ff[`PCG_ALT_GPUD_BIT];
assign async_timer_clock_select = alt_ctrl_ff[`PCG_ALT_ASYNC_BIT];
assign two_wire_enable = alt_ctrl_ff[`PCG_ALT_TWI_BIT];

////////////////////////////////////////////////////////////////////////////
// Bus slave: zero wait states, always OKAY
assign idx_a = haddr[`PCG_ADDR_MSB:`PCG_ADDR_LSB];
assign xfer = hsel && hready &&
	(htrans == `PCG_HTRANS_NONSEQ || htrans == `PCG_HTRANS_SEQ);
assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign hrdata = rdata_ff;

// RULE13 RULE16 two flop synchroniser
pcg_sync2 #(
	.WIDTH(WIDTH)
) u_sync (
	.hclk(hclk),
	.hresetn(hresetn),
	.async_in(port_pin_in),
	.sync_out(c_pin_levels)
);
assign c_pin_sync = c_pin_levels;

// RULE5 read mux; RULE6 pin levels are not stored
always @* begin
	nxt_rdata = 32'h0000_0000;
	case (idx_a)
	`PCG_PIN_LEVELS_IDX: nxt_rdata[WIDTH-1:0] = c_pin_levels;
	`PCG_DIRECTION_IDX: nxt_rdata[WIDTH-1:0] = c_direction_reg_ff;
	`PCG_OUTPUT_LATCH_IDX: nxt_rdata[WIDTH-1:0] = c_output_latch_ff;
	`PCG_ALT_CTRL_IDX: nxt_rdata[2:0] = alt_ctrl_ff;
	default: nxt_rdata = 32'h0000_0000;
	endcase
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_pend_ff <= 1'b0;
		rd_pend_ff <= 1'b0;
		idx_ff <= 8'h00;
		rdata_ff <= 32'h0000_0000;
	end else begin
		wr_pend_ff <= xfer && hwrite;
		rd_pend_ff <= xfer && !hwrite;
		if (xfer)
			idx_ff <= idx_a;
		if (xfer && !hwrite)
			rdata_ff <= nxt_rdata;
	end
end

// RULE14 RULE15 writable registers, cleared on reset
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		c_output_latch_ff <= `PCG_BYTE_RESET;
		c_direction_reg_ff <= `PCG_BYTE_RESET;
		alt_ctrl_ff <= `PCG_ALT_RESET;
	end else if (wr_pend_ff) begin
		case (idx_ff)
		`PCG_DIRECTION_IDX: c_direction_reg_ff <= hwdata[WIDTH-1:0];
		`PCG_OUTPUT_LATCH_IDX: c_output_latch_ff <= hwdata[WIDTH-1:0];
		`PCG_ALT_CTRL_IDX: alt_ctrl_ff <= hwdata[2:0];
		default: c_output_latch_ff <= c_output_latch_ff;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// RULE11 RULE12 spike filters on the two-wire inputs
pcg_spike_filter #(
	.CNT_W(4),
	.STABLE_CYCLES(SPIKE_CYC[3:0])
) u_sda_filt (
	.hclk(hclk),
	.hresetn(hresetn),
	.level_in(c_pin_levels[`PCG_TW_DATA_PIN]),
	.level_out(tw_data_filt)
);
pcg_spike_filter #(
	.CNT_W(4),
	.STABLE_CYCLES(SPIKE_CYC[3:0])
) u_scl_filt (
	.hclk(hclk),
	.hresetn(hresetn),
	.level_in(c_pin_levels[`PCG_TW_CLOCK_PIN]),
	.level_out(tw_clock_filt)
);
assign tw_data_in = two_wire_enable ? tw_data_filt : 1'b1;
assign tw_clock_in = two_wire_enable ? tw_clock_filt : 1'b1;
// Analog oscillator path; crystal bypasses the synchroniser
assign osc_amp_in = async_timer_clock_select ?
	port_pin_in[`PCG_OSC_IN_PIN] : 1'b0;

////////////////////////////////////////////////////////////////////////////
// RULE8 one pin cell per bit; pins 7, 6, 1 and 0 add alternate takeover
genvar gi;
generate
	for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
		wire osc_out_pin;
		wire osc_in_pin;
		wire tw_pin;
		wire tw_low;
		wire gp_oe;
		assign osc_out_pin = async_timer_clock_select &&
			(gi == `PCG_OSC_OUT_PIN);
		assign osc_in_pin = async_timer_clock_select &&
			(gi == `PCG_OSC_IN_PIN);
		assign tw_pin = two_wire_enable &&
			(gi == `PCG_TW_DATA_PIN || gi == `PCG_TW_CLOCK_PIN);
		assign tw_low = (gi == `PCG_TW_DATA_PIN) ?
			tw_data_drive_low : tw_clock_drive_low;
		// RULE1 direction; RULE7 direction clears asynchronously
		assign gp_oe = c_direction_reg_ff[gi];
		// RULE9 RULE10 RULE11 RULE12 alternate takeover
		assign port_pin_oe[gi] = osc_out_pin ? 1'b1 :
			osc_in_pin ? 1'b0 :
			tw_pin ? tw_low : gp_oe;
		// RULE2 push-pull from the latch
		assign port_pin_out[gi] = osc_out_pin ? osc_amp_out :
			tw_pin ? 1'b0 : c_output_latch_ff[gi];
		// RULE3 RULE4 pull-up only for general inputs
		assign port_pin_pullup[gi] = !osc_out_pin && !osc_in_pin &&
			!tw_pin && !gp_oe && c_output_latch_ff[gi] &&
			!global_pullup_disable;
		assign port_pin_slew_limit[gi] = tw_pin &&
			(gi == `PCG_TW_DATA_PIN);
	end
endgenerate

endmodule

// ---- verif/pcg_port_c_monitor.sv ----
// Port rule checker for the port C block
`timescale 1ns/1ps
module pcg_mon (
	input wire hclk,
	input wire hresetn,
	input wire [7:0] port_pin_in,
	input wire [7:0] port_pin_out,
	input wire [7:0] port_pin_oe,
	input wire [7:0] port_pin_pullup,
	input wire [7:0] port_pin_slew_limit,
	input wire [7:0] c_pin_sync,
	input wire osc_amp_out,
	input wire osc_amp_in,
	input wire tw_data_drive_low,
	input wire tw_clock_drive_low,
	input wire tw_data_in,
	input wire tw_clock_in,
	input wire async_timer_clock_select,
	input wire two_wire_enable
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// Reset must float pins with no help from the clock
	a_reset_hiz: assert property (disable iff (1'b0)
		!hresetn |-> port_pin_oe == 8'h00) else $error("pin driven in reset");
	a_pull_off: assert property ((port_pin_pullup & port_pin_oe) == 8'h00)
		else $error("pull-up on output");
	a_sync_two: assert property ($past(hresetn) && $past(hresetn, 2) |->
		c_pin_sync == $past(port_pin_in, 2)) else $error("sync delay");
	a_osc_out: assert property (async_timer_clock_select |->
		port_pin_oe[7] && port_pin_out[7] == osc_amp_out) else $error("pin 7");
	a_osc_in: assert property (osc_amp_in ==
		(async_timer_clock_select & port_pin_in[6]) &&
		!(async_timer_clock_select && port_pin_oe[6])) else $error("pin 6");
	a_tw_data: assert property (two_wire_enable |->
		port_pin_oe[1] == tw_data_drive_low && !port_pin_out[1] &&
		port_pin_slew_limit[1]) else $error("pin 1");
	a_tw_clock: assert property (two_wire_enable |->
		port_pin_oe[0] == tw_clock_drive_low && !port_pin_out[0])
		else $error("pin 0");
	a_tw_idle: assert property (!two_wire_enable |->
		tw_data_in && tw_clock_in && port_pin_slew_limit == 8'h00)
		else $error("two-wire idle");
	c_osc: cover property (async_timer_clock_select);
	c_twi: cover property (two_wire_enable && tw_data_drive_low);
	c_pull: cover property (port_pin_pullup != 8'h00);
endmodule
bind pcg_port_c pcg_mon pcg_mon_inst (.*);

// ---- verif/pcg_board.sv ----
// Board model: pin wiring, external drivers and floating lines
`timescale 1ns/1ps
module pcg_board (
	input wire hclk,
	input wire [7:0] pin_out,
	input wire [7:0] pin_oe,
	input wire [7:0] pin_pullup,
	input wire [7:0] ext_val,
	input wire [7:0] ext_en,
	output wire [7:0] level
);
	// Undriven lines wander so a missed pull-up cannot pass as high
	logic [7:0] flt_ff = 8'h55;
	always @(posedge hclk) flt_ff <= ~flt_ff;
	assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
		(~pin_oe & ~ext_en & (pin_pullup | flt_ff));
endmodule

// ---- verif/test_port_c_gpio_with_alternates.sv ----
// Self-checking bench for the port C block
`timescale 1ns/1ps
module test_port_c_gpio_with_alternates;
	logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
	logic osc = 1'b0, dlow = 1'b0, twd, twc, rdy;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h14CCB;
	logic [7:0] ev = 8'h00, en = 8'hFF, lvl, po, oe, pu, d, l, m;
	logic [7:0] exp_q[$];
	int n_mismatch = 0, comparisons = 0;
	initial forever #5 hclk = ~hclk;
	pcg_port_c pcg_port_c_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
		.hresp(), .port_pin_in(lvl), .port_pin_out(po), .port_pin_oe(oe),
		.port_pin_pullup(pu), .port_pin_slew_limit(), .c_pin_sync(),
		.osc_amp_out(osc), .osc_amp_in(), .tw_data_drive_low(dlow),
		.tw_clock_drive_low(1'b0), .tw_data_in(twd), .tw_clock_in(twc),
		.async_timer_clock_select(), .two_wire_enable());
	pcg_board pcg_board_inst (.hclk(hclk), .pin_out(po), .pin_oe(oe),
		.pin_pullup(pu), .ext_val(ev), .ext_en(en), .level(lvl));
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			n_mismatch++;
			$display("wrong value at %0t: %h not %h", $time, seen, want);
		end
	endtask
	// Reads note the expected byte; the watcher below compares it
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (!rdy) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		if (!w) exp_q.push_back(v);
		@(posedge hclk);
		while (!rdy) @(posedge hclk);
	endtask
	always @(posedge hclk) begin
		if (rd_ph && rdy) check(hrdata[7:0], exp_q.pop_front());
		rd_ph <= htrans[1] && !hwrite && rdy;
	end
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		report_and_stop;
	end
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 8'h4C; a < 8'h60; a += 4) bus(0, a[7:0], 8'h00);
		$display("reset values done");
		repeat (8) begin
			repeat (8) seed = lfsr(seed);
			d = seed[7:0];
			l = seed[15:8];
			m = seed[24] ? 8'h00 : ~d & l;
			en <= ~d & ~m;
			ev <= seed[23:16];
			bus(1, 8'h58, {7'h0, seed[24]});
			bus(1, 8'h50, d);
			bus(1, 8'h54, l);
			#1 check(oe, d);
			check(pu, m);
			repeat (3) @(posedge hclk);
			bus(0, 8'h4C, d & l | ~d & ~m & seed[23:16] | m);
			bus(0, 8'h54, l);
			bus(0, 8'h50, d);
		end
		$display("random port done");
		osc <= 1'b1;
		dlow <= 1'b1;
		en <= 8'h41;
		ev <= 8'h41;
		bus(1, 8'h50, 8'hFF);
		bus(1, 8'h54, 8'h00);
		bus(1, 8'h58, 8'h06);
		repeat (3) @(posedge hclk);
		bus(0, 8'h4C, 8'hC1);
		dlow <= 1'b0;
		en <= 8'h43;
		ev <= 8'h43;
		repeat (10) @(posedge hclk);
		// A 30 ns dip must not pass the spike filter
		ev <= 8'h41;
		repeat (3) @(posedge hclk);
		ev <= 8'h43;
		repeat (8) @(posedge hclk);
		#1 check({7'h0, twd}, 8'h01);
		check({7'h0, twc}, 8'h01);
		ev <= 8'h40;
		repeat (12) @(posedge hclk);
		#1 check({7'h0, twd}, 8'h00);
		check({7'h0, twc}, 8'h00);
		#3 hresetn = 1'b0;
		#1 check(oe, 8'h00);
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, 8'h54, 8'h00);
		$display("alternates and reset done");
		report_and_stop;
	end
endmodule
